// ### core/dba_pkg.sv
// Shared constants and types of the bus-mode and channel arbiter
package dba_pkg;
	localparam int          NCH          = 4;
	localparam int          ADDR_W       = 8;
	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_STAT     = 8'h04;
	localparam logic [3:0]  OFS_CH_HI    = 4'h1;
	// Control register bits
	localparam int          CTL_EN       = 0;
	localparam int          CTL_RR       = 1;
	localparam int          CTL_INT      = 2;
	localparam int          CTL_INT64    = 3;
	localparam logic [3:0]  CTL_MASK     = 4'hf;
	// Channel configuration bits (bits 31:16 hold the unit count)
	localparam int          CF_EN        = 0;
	localparam int          CF_SRC       = 1;
	localparam int          CF_BURST     = 3;
	localparam int          CF_DUAL      = 4;
	localparam int          CF_TRANSFER_ACKNOWLEDGE_OUTPUT      = 5;
	localparam int          CF_PERI      = 6;
	localparam int          CF_TMR_REQ   = 7;
	localparam int          CF_TMR_SRC   = 8;
	localparam int          CF_SZ        = 9;
	localparam int          CF_SZ_OK     = 11;
	localparam logic [15:0] CFG_MASK     = 16'h0fff;
	localparam int          CNT_LO       = 16;
	// Status register fields
	localparam int          ST_DONE      = 0;
	localparam int          ST_ERR       = 4;
	localparam int          ST_CUR       = 8;
	localparam int          ST_HELD      = 10;
	localparam int          ST_PTR       = 12;
	// Request sources and sizes
	localparam logic [1:0]  SRC_AUTO     = 2'h0;
	localparam logic [1:0]  SRC_EXT      = 2'h1;
	localparam logic [1:0]  SRC_PERI     = 2'h2;
	localparam logic [1:0]  SZ_128       = 2'h3;
	// Intermittent gaps, in bus-clock cycles (bus clock equals aclk here)
	localparam logic [6:0]  GAP_SHORT    = 7'h10;
	localparam logic [6:0]  GAP_LONG     = 7'h40;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACQUIRE,
		ST_XFER,
		ST_DECIDE,
		ST_GAP
	} dba_state_type;
endpackage

// ### core/dba_chan_check.sv
// Legality check of one channel's request mode, bus mode, size and number
`timescale 1ns/10ps
`default_nettype none
module dba_chan_check #(
	parameter int CH = 0
) (
	input  wire logic [15:0] cfg,      // Channel configuration bits
	output logic             legal     // Configuration may run
);
	logic       ext;
	logic       peri_req;
	logic       low_ch;
	logic [1:0] src;
	logic       bad;

	assign src      = cfg[dba_pkg::CF_SRC +: 2];
	assign ext      = (src == dba_pkg::SRC_EXT);
	assign peri_req = (src == dba_pkg::SRC_PERI);
	assign low_ch   = (CH < 2);

	always_comb begin
		bad = 1'b0;
		if (src == 2'h3)
			bad = 1'b1;
		if (ext && !low_ch)
			bad = 1'b1;
		if (peri_req && !cfg[dba_pkg::CF_TMR_REQ] && cfg[dba_pkg::CF_BURST])
			bad = 1'b1;
		if (!cfg[dba_pkg::CF_DUAL]) begin
			// Single address: acknowledged device, external request, no 128-bit unit
			if (!cfg[dba_pkg::CF_TRANSFER_ACKNOWLEDGE_OUTPUT] || !ext || !low_ch || cfg[dba_pkg::CF_PERI])
				bad = 1'b1;
			if (cfg[dba_pkg::CF_SZ +: 2] == dba_pkg::SZ_128)
				bad = 1'b1;
		end else if (cfg[dba_pkg::CF_TRANSFER_ACKNOWLEDGE_OUTPUT]) begin
			if (!ext || !low_ch || cfg[dba_pkg::CF_PERI])
				bad = 1'b1;
		end else if (!cfg[dba_pkg::CF_PERI]) begin
			if (peri_req && !cfg[dba_pkg::CF_TMR_REQ])
				bad = 1'b1;
		end else begin
			if (!cfg[dba_pkg::CF_SZ_OK])
				bad = 1'b1;
			if (cfg[dba_pkg::CF_BURST] && !cfg[dba_pkg::CF_TMR_SRC])
				bad = 1'b1;
		end
	end

	assign legal = !bad;
endmodule // dba_chan_check
`default_nettype wire

// ### core/dba_arbiter.sv
// Four-channel transfer controller: bus-mode control, arbitration, register slave
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dba_arbiter (
	input  wire logic        aclk,                         // Clock, 25 MHz
	input  wire logic        aresetn,                      // Synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,                 // Write address
	input  wire logic        s_axi_awvalid,                // Write address valid
	output logic             s_axi_awready,                // Write address ready
	input  wire logic [31:0] s_axi_wdata,                  // Write data
	input  wire logic [3:0]  s_axi_wstrb,                  // Write byte enables
	input  wire logic        s_axi_wvalid,                 // Write data valid
	output logic             s_axi_wready,                 // Write data ready
	output logic [1:0]       s_axi_bresp,                  // Write response
	output logic             s_axi_bvalid,                 // Write response valid
	input  wire logic        s_axi_bready,                 // Write response ready
	input  wire logic [7:0]  s_axi_araddr,                 // Read address
	input  wire logic        s_axi_arvalid,                // Read address valid
	output logic             s_axi_arready,                // Read address ready
	output logic [31:0]      s_axi_rdata,                  // Read data
	output logic [1:0]       s_axi_rresp,                  // Read response
	output logic             s_axi_rvalid,                 // Read data valid
	input  wire logic        s_axi_rready,                 // Read data ready
	input  wire logic [1:0]  transfer_request_input_n,     // External requests, low level
	input  wire logic [3:0]  periph_request,               // On-chip peripheral requests
	output logic             bus_request,                  // Bus wanted from other master
	input  wire logic        bus_grant,                    // Bus handed over
	output logic             cycle_start,                  // Unit cycle to bus state ctrl
	output logic [1:0]       cycle_channel,                // Channel of the unit cycle
	output logic [1:0]       cycle_size,                   // Size code of the unit
	output logic             cycle_dual,                   // Dual address unit
	input  wire logic        cycle_done,                   // Bus state controller finished
	output logic [1:0]       transfer_acknowledge_output   // Acknowledge, channels 0 and 1
);
	typedef struct packed {
		dba_pkg::dba_state_type st;
		logic [3:0]             ctrl;
		logic [3:0]             done;
		logic [3:0][15:0]       cfg;
		logic [3:0][15:0]       cnt;
		logic [1:0]             ptr;
		logic [1:0]             cur;
		logic                   last_cs;
		logic [6:0]             gap;
		logic                   aw_ok;
		logic [7:0]             awaddr;
		logic                   w_ok;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [1:0]             rresp;
		logic [31:0]            rdata;
		logic                   breq;
		logic                   cyc;
		logic [1:0]             ack;
	} dba_regs_type;

	dba_regs_type s_ff;
	dba_regs_type nxt_s;

	logic [3:0] legal;
	logic [3:0] pend;
	logic [3:0] burst;
	logic [3:0] elig;
	logic       any_burst;
	logic       have_win;
	logic [1:0] win;
	logic [1:0] base;

	genvar g;
	generate
		for (g = 0; g < dba_pkg::NCH; g++) begin : g_ch
			logic [1:0] src;
			logic       req;
			assign src = s_ff.cfg[g][dba_pkg::CF_SRC +: 2];
			if (g < 2) begin : g_ext
				// Level detection: a low input is a live request
				assign req = (src == dba_pkg::SRC_AUTO) ||
					(src == dba_pkg::SRC_EXT && !transfer_request_input_n[g]) ||
					(src == dba_pkg::SRC_PERI && periph_request[g]);
			end else begin : g_int
				assign req = (src == dba_pkg::SRC_AUTO) ||
					(src == dba_pkg::SRC_PERI && periph_request[g]);
			end
			dba_chan_check #(.CH(g)) u_check (
				.cfg   (s_ff.cfg[g]),
				.legal (legal[g])
			);
			assign burst[g] = s_ff.cfg[g][dba_pkg::CF_BURST];
			assign pend[g]  = s_ff.ctrl[dba_pkg::CTL_EN] && s_ff.cfg[g][dba_pkg::CF_EN] &&
				legal[g] && (s_ff.cnt[g] != 16'h0000) && req;
		end
	endgenerate

	assign any_burst = |(pend & burst);
	// After a cycle-steal unit the waiting burst gets the next unit
	assign elig      = (s_ff.last_cs && any_burst) ? (pend & burst) : pend;
	assign base      = s_ff.ctrl[dba_pkg::CTL_RR] ? s_ff.ptr : 2'h0;

	always_comb begin
		logic [1:0] idx;
		idx      = 2'h0;
		have_win = 1'b0;
		win      = 2'h0;
		for (int k = dba_pkg::NCH - 1; k >= 0; k--) begin
			idx = base + 2'(k);
			if (elig[idx]) begin
				have_win = 1'b1;
				win      = idx;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[8*b +: 8] = d[8*b +: 8];
		end
		return r;
	endfunction

	always_comb begin
		logic [31:0] old;
		logic [31:0] val;
		logic [1:0]  ch;
		nxt_s = s_ff;
		old   = 32'h0000_0000;
		val   = 32'h0000_0000;
		ch    = 2'h0;
		// Write channels are taken in either order, answered when both are in
		if (s_axi_awvalid && !s_ff.aw_ok) begin
			nxt_s.aw_ok  = 1'b1;
			nxt_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_ff.w_ok) begin
			nxt_s.w_ok  = 1'b1;
			nxt_s.wdata = s_axi_wdata;
			nxt_s.wstrb = s_axi_wstrb;
		end
		if (s_ff.bvalid && s_axi_bready)
			nxt_s.bvalid = 1'b0;
		// Hardware completion flags; software clear below loses to a new set
		if (s_ff.st == dba_pkg::ST_XFER && cycle_done) begin
			nxt_s.cyc     = 1'b0;
			nxt_s.ack     = 2'h0;
			nxt_s.last_cs = !burst[s_ff.cur];
			nxt_s.cnt[s_ff.cur] = s_ff.cnt[s_ff.cur] - 16'h0001;
			if (s_ff.ctrl[dba_pkg::CTL_RR])
				nxt_s.ptr = s_ff.cur + 2'h1;
		end
		if (s_ff.aw_ok && s_ff.w_ok && !s_ff.bvalid) begin
			nxt_s.aw_ok  = 1'b0;
			nxt_s.w_ok   = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp  = dba_pkg::RESP_OKAY;
			ch           = s_ff.awaddr[3:2];
			if (s_ff.awaddr == dba_pkg::OFS_CTRL) begin
				val        = merge({28'h0000000, s_ff.ctrl}, s_ff.wdata, s_ff.wstrb);
				nxt_s.ctrl = val[3:0] & dba_pkg::CTL_MASK;
			end else if (s_ff.awaddr == dba_pkg::OFS_STAT) begin
				if (s_ff.wstrb[0])
					nxt_s.done = s_ff.done & ~s_ff.wdata[dba_pkg::ST_DONE +: 4];
			end else if (s_ff.awaddr[7:4] == dba_pkg::OFS_CH_HI && s_ff.awaddr[1:0] == 2'h0) begin
				old             = {nxt_s.cnt[ch], s_ff.cfg[ch]};
				val             = merge(old, s_ff.wdata, s_ff.wstrb);
				nxt_s.cfg[ch]   = val[15:0] & dba_pkg::CFG_MASK;
				nxt_s.cnt[ch]   = val[dba_pkg::CNT_LO +: 16];
			end else begin
				nxt_s.bresp = dba_pkg::RESP_SLVERR;
			end
		end
		if (s_ff.st == dba_pkg::ST_XFER && cycle_done && s_ff.cnt[s_ff.cur] == 16'h0001)
			nxt_s.done[s_ff.cur] = 1'b1;
		// Read path, one outstanding read
		if (s_ff.rvalid && s_axi_rready)
			nxt_s.rvalid = 1'b0;
		if (s_axi_arvalid && !s_ff.rvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp  = dba_pkg::RESP_OKAY;
			nxt_s.rdata  = 32'h0000_0000;
			ch           = s_axi_araddr[3:2];
			if (s_axi_araddr == dba_pkg::OFS_CTRL)
				nxt_s.rdata[3:0] = s_ff.ctrl;
			else if (s_axi_araddr == dba_pkg::OFS_STAT) begin
				nxt_s.rdata[dba_pkg::ST_DONE +: 4] = s_ff.done;
				nxt_s.rdata[dba_pkg::ST_ERR +: 4]  = ~legal & {s_ff.cfg[3][dba_pkg::CF_EN],
					s_ff.cfg[2][dba_pkg::CF_EN], s_ff.cfg[1][dba_pkg::CF_EN],
					s_ff.cfg[0][dba_pkg::CF_EN]};
				nxt_s.rdata[dba_pkg::ST_CUR +: 2]  = s_ff.cur;
				nxt_s.rdata[dba_pkg::ST_HELD]      = s_ff.breq && bus_grant;
				nxt_s.rdata[dba_pkg::ST_PTR +: 2]  = s_ff.ptr;
			end else if (s_axi_araddr[7:4] == dba_pkg::OFS_CH_HI && s_axi_araddr[1:0] == 2'h0)
				nxt_s.rdata = {s_ff.cnt[ch], s_ff.cfg[ch]};
			else
				nxt_s.rresp = dba_pkg::RESP_SLVERR;
		end
		// Bus-mode sequencer
		case (s_ff.st)
			dba_pkg::ST_IDLE: begin
				if (|pend) begin
					nxt_s.breq = 1'b1;
					nxt_s.st   = dba_pkg::ST_ACQUIRE;
				end
			end
			dba_pkg::ST_ACQUIRE: begin
				if (!have_win) begin
					nxt_s.breq = 1'b0;
					nxt_s.st   = dba_pkg::ST_IDLE;
				end else if (bus_grant) begin
					nxt_s.cur = win;
					nxt_s.cyc = 1'b1;
					nxt_s.ack = {1'b0, win == 2'h0} | {win == 2'h1, 1'b0};
					if (s_ff.cfg[win][dba_pkg::CF_SRC +: 2] != dba_pkg::SRC_EXT)
						nxt_s.ack = 2'h0;
					nxt_s.st  = dba_pkg::ST_XFER;
				end
			end
			dba_pkg::ST_XFER: begin
				// Cycle length is set outside by the bus state controller
				if (cycle_done)
					nxt_s.st = dba_pkg::ST_DECIDE;
			end
			dba_pkg::ST_DECIDE: begin
				if (any_burst && have_win) begin
					nxt_s.cur = win;
					nxt_s.cyc = 1'b1;
					nxt_s.ack = {1'b0, win == 2'h0} | {win == 2'h1, 1'b0};
					if (s_ff.cfg[win][dba_pkg::CF_SRC +: 2] != dba_pkg::SRC_EXT)
						nxt_s.ack = 2'h0;
					nxt_s.st  = dba_pkg::ST_XFER;
				end else begin
					// No burst left wanting the bus: hand it back
					nxt_s.breq    = 1'b0;
					nxt_s.last_cs = 1'b0;
					if (s_ff.ctrl[dba_pkg::CTL_INT]) begin
						nxt_s.gap = s_ff.ctrl[dba_pkg::CTL_INT64] ?
							dba_pkg::GAP_LONG - 7'h01 : dba_pkg::GAP_SHORT - 7'h01;
						nxt_s.st  = dba_pkg::ST_GAP;
					end else begin
						nxt_s.st  = dba_pkg::ST_IDLE;
					end
				end
			end
			dba_pkg::ST_GAP: begin
				if (s_ff.gap == 7'h00)
					nxt_s.st = dba_pkg::ST_IDLE;
				else
					nxt_s.gap = s_ff.gap - 7'h01;
			end
			default: begin
				nxt_s.st = dba_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff     <= '0;
			s_ff.st  <= dba_pkg::ST_IDLE;
			s_ff.ptr <= 2'h0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign s_axi_awready               = !s_ff.aw_ok;
	assign s_axi_wready                = !s_ff.w_ok;
	assign s_axi_bvalid                = s_ff.bvalid;
	assign s_axi_bresp                 = s_ff.bresp;
	assign s_axi_arready               = !s_ff.rvalid;
	assign s_axi_rvalid                = s_ff.rvalid;
	assign s_axi_rresp                 = s_ff.rresp;
	assign s_axi_rdata                 = s_ff.rdata;
	assign bus_request                 = s_ff.breq;
	assign cycle_start                 = s_ff.cyc;
	assign cycle_channel               = s_ff.cur;
	assign cycle_size                  = s_ff.cfg[s_ff.cur][dba_pkg::CF_SZ +: 2];
	assign cycle_dual                  = s_ff.cfg[s_ff.cur][dba_pkg::CF_DUAL];
	assign transfer_acknowledge_output = s_ff.ack;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_burst_keeps_bus: assert property (
		(s_ff.st == dba_pkg::ST_DECIDE && any_burst) |=> (bus_request && cycle_start))
		else $error("burst pending but bus not kept");
	a_release_no_burst: assert property (
		(s_ff.st == dba_pkg::ST_DECIDE && !any_burst) |=> (!bus_request ##1 !cycle_start))
		else $error("bus not returned after unit");
	a_legal_only: assert property (
		$rose(cycle_start) |-> legal[cycle_channel])
		else $error("illegal channel configuration started");
	a_ext_low_chan: assert property (
		(cycle_start && s_ff.cfg[cycle_channel][dba_pkg::CF_SRC +: 2] == dba_pkg::SRC_EXT)
			|-> cycle_channel < 2'h2)
		else $error("external request on upper channel");
	a_fixed_preempt: assert property (
		(s_ff.st == dba_pkg::ST_DECIDE && !s_ff.ctrl[dba_pkg::CTL_RR] && elig[0] && any_burst)
			|=> (cycle_start && cycle_channel == 2'h0))
		else $error("higher channel not served first");
	a_alternate_units: assert property (
		(s_ff.st == dba_pkg::ST_XFER && cycle_done && !burst[s_ff.cur] && any_burst)
			|=> ##1 (cycle_start && burst[cycle_channel] && bus_request))
		else $error("burst unit not interleaved");
	a_cycle_held: assert property (
		(cycle_start && !cycle_done) |=> (cycle_start && $stable(cycle_channel)))
		else $error("unit cycle dropped before done");
	a_gap_wait: assert property (
		(s_ff.st == dba_pkg::ST_DECIDE && !any_burst && s_ff.ctrl[dba_pkg::CTL_INT])
			|=> !bus_request [*8] ##1 !bus_request [*8])
		else $error("bus re-acquired inside the gap");
	a_rr_rotate: assert property (
		(s_ff.st == dba_pkg::ST_XFER && cycle_done && s_ff.ctrl[dba_pkg::CTL_RR])
			|=> s_ff.ptr == $past(s_ff.cur) + 2'h1)
		else $error("round-robin pointer not rotated");

	c_burst_chain: cover property (s_ff.st == dba_pkg::ST_DECIDE && any_burst);
	c_interleave: cover property (s_ff.last_cs && any_burst && s_ff.st == dba_pkg::ST_DECIDE);
	c_gap: cover property (s_ff.st == dba_pkg::ST_GAP && s_ff.gap == 7'h00);
	c_ext_drop: cover property ($rose(transfer_request_input_n[0]) && cycle_start);
endmodule // dba_arbiter
`default_nettype wire

// ### bench/dba_bus_partner.sv
// Model of the other bus master and of the bus state controller
`timescale 1ns/10ps
`default_nettype none
module dba_bus_partner (
	input  wire logic       aclk,        // Clock
	input  wire logic       aresetn,     // Synchronous reset, active low
	input  wire logic       bus_request, // Bus wanted by the controller
	output logic            bus_grant,   // Bus handed over
	input  wire logic       cycle_start, // Unit cycle requested
	output logic            cycle_done,  // Unit finished, one-cycle pulse
	input  wire logic [1:0] lat          // Wait states of the running unit
);
	logic [1:0] wait_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_grant  <= 1'b0;
			cycle_done <= 1'b0;
			wait_ff    <= 2'h0;
		end else begin
			bus_grant  <= bus_request;
			cycle_done <= 1'b0;
			if (cycle_start && !cycle_done) begin
				// Unit length is set here, never by the requester
				if (wait_ff >= lat) begin
					cycle_done <= 1'b1;
					wait_ff    <= 2'h0;
				end else begin
					wait_ff <= wait_ff + 2'h1;
				end
			end
		end
	end
endmodule // dba_bus_partner
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench of the bus-mode and channel arbiter
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, breq, bgnt, cst, cdual, cdone;
	logic        prev_br;
	logic [4:0]  unit_sig;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, st;
	logic [3:0]  wstrb;
	logic [3:0]  preq = 4'h0;
	logic [1:0]  lat  = 2'h0;
	logic [1:0]  bresp, rresp, req_n, cch, csz, ack, rsp;
	logic [1:0]  seq[$];
	int          failures, n_checks, seed, rel, lowcnt, gap_seen, n, i0;
	logic [23:0] tbl [11] = '{24'h020033, 24'h100033, 24'h000623, 24'h100423, 24'h000021,
		24'h00085d, 24'h100855, 24'h1009dd, 24'h000055, 24'h030015, 24'h130095};

	dba_arbiter dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .transfer_request_input_n(req_n), .periph_request(preq),
		.bus_request(breq), .bus_grant(bgnt), .cycle_start(cst), .cycle_channel(cch),
		.cycle_size(csz), .cycle_dual(cdual), .cycle_done(cdone),
		.transfer_acknowledge_output(ack));
	dba_bus_partner partner_u (.aclk(aclk), .aresetn(aresetn), .bus_request(breq),
		.bus_grant(bgnt), .cycle_start(cst), .cycle_done(cdone), .lat(lat));

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		lat  <= 2'($random(seed));
		preq <= 4'($random(seed));
	end
	// Records served channels, bus releases and the length of each bus gap
	always @(posedge aclk) begin
		if (!aresetn) begin
			seq.delete();
			rel      <= 0;
			lowcnt   <= 0;
			gap_seen <= 0;
		end else begin
			if (cst && cdone) begin
				seq.push_back(cch);
				unit_sig <= {ack, csz, cdual};
			end
			if (prev_br && !breq) rel <= rel + 1;
			lowcnt <= breq ? 0 : lowcnt + 1;
			if (breq && !prev_br && rel > 0) gap_seen <= lowcnt;
		end
		prev_br <= breq;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		if (failures == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset(input int c);
		aresetn <= 1'b0;
		repeat (c) @(posedge aclk);
		aresetn <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hf;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta = ta || awready;
			tw = tw || wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic cfg(input int ch, input logic [15:0] bits, input logic [15:0] cnt);
		wr({dba_pkg::OFS_CH_HI, 2'(ch), 2'b00}, {cnt, bits}, rsp);
	endtask
	task automatic wait_units(input int k);
		while (seq.size() < k) @(posedge aclk);
		repeat (8) @(posedge aclk);
	endtask
	// Channel expected k units after channel zero first wins the bus
	function automatic logic [1:0] exp_ch(input int m, input int k);
		return (k < (m ? 5 : 3) && (m == 0 || k % 2 == 0)) ? 2'h0 : 2'h1;
	endfunction

	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		final_report();
	end
	initial begin
		seed = 56161;
		failures = 0;
		n_checks = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		req_n = 2'h3;
		do_reset(12);
		rd(dba_pkg::OFS_STAT, st, rsp);
		chk(st, 32'h0);
		wr(8'h30, 32'h1, rsp);
		chk(32'(rsp), 32'(dba_pkg::RESP_SLVERR));
		rd(8'h30, st, rsp);
		chk(st, 32'h0);
		chk(32'(rsp), 32'(dba_pkg::RESP_SLVERR));
		wr(dba_pkg::OFS_CTRL, 32'h1, rsp);
		foreach (tbl[i]) begin
			cfg(int'(tbl[i][19:16]), tbl[i][15:0], 16'h0);
			rd(dba_pkg::OFS_STAT, st, rsp);
			chk(32'(st[dba_pkg::ST_ERR + tbl[i][17:16]]), 32'(!tbl[i][20]));
			cfg(int'(tbl[i][19:16]), 16'h0, 16'h0);
		end
		n = 6 + ($unsigned($random(seed)) % 3);
		req_n <= 2'h2;
		cfg(0, 16'h003b, 16'(n));
		while (seq.size() < 2) @(posedge aclk);
		req_n <= 2'h3;
		repeat (30) @(posedge aclk);
		rd({dba_pkg::OFS_CH_HI, 4'h0}, st, rsp);
		chk(32'({breq, rel[3:0], seq.size() < n}), 32'h03);
		chk(32'(st[31:16]), 32'(n - seq.size()));
		// Last unit: acknowledge on channel zero, 8-bit, dual address
		chk(32'(unit_sig), 32'h09);
		for (int m = 0; m < 2; m++) begin
			do_reset(2);
			wr(dba_pkg::OFS_CTRL, 32'h1, rsp);
			n = 8 + ($unsigned($random(seed)) % 4);
			cfg(1, 16'h0019, 16'(n));
			while (seq.size() < 2) @(posedge aclk);
			cfg(0, m ? 16'h0011 : 16'h0019, 16'h0003);
			wait_units(n + 3);
			i0 = 0;
			while (i0 < seq.size() - 1 && seq[i0] != 2'h0) i0++;
			chk(32'(i0 <= 5), 32'h1);
			for (int k = 0; k < n + 3 - i0; k++)
				chk(32'(seq[i0 + k]), 32'(exp_ch(m, k)));
			chk(rel, 1);
		end
		do_reset(2);
		wr(dba_pkg::OFS_CTRL, 32'h1, rsp);
		cfg(2, 16'h0411, 16'h0003);
		wait_units(3);
		chk(rel, 3);
		// Memory to memory, 32-bit units, no acknowledge
		chk(32'(unit_sig), 32'h05);
		for (int g = 0; g < 2; g++) begin
			do_reset(2);
			wr(dba_pkg::OFS_CTRL, g ? 32'hd : 32'h5, rsp);
			cfg(3, 16'h0011, 16'h0002);
			wait_units(2);
			chk(32'(gap_seen >= (g ? 64 : 16) && gap_seen <= (g ? 68 : 20)), 32'h1);
		end
		// All channels cycle-steal, so round-robin sees no mixed modes
		do_reset(2);
		wr(dba_pkg::OFS_CTRL, 32'h3, rsp);
		cfg(2, 16'h0011, 16'h0001);
		wait_units(1);
		wr(dba_pkg::OFS_CTRL, 32'h2, rsp);
		cfg(0, 16'h0011, 16'h0001);
		cfg(3, 16'h0011, 16'h0001);
		wr(dba_pkg::OFS_CTRL, 32'h3, rsp);
		wait_units(3);
		rd(dba_pkg::OFS_STAT, st, rsp);
		chk(32'({seq[1], seq[2], st[dba_pkg::ST_PTR +: 2]}), 32'h31);
		final_report();
	end
endmodule // tb_top
`default_nettype wire
